/* verilog/mtxcs_top.sv */
// Transmit configuration, gap, padding and statistics for one switch port
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module mtxcs_top
   import mtxcs_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int LEN_W = 12,
   parameter int CNT_W = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   // MAC core transmit path
   input wire logic half_duplex,
   input wire logic bit_tick,
   input wire logic tx_start,
   input wire logic [LEN_W-1:0] tx_len,
   input wire logic tx_end,
   input wire mtxcs_evt_t evt,
   // Controls toward the MAC core
   output logic tx_permit_r,
   output logic len_valid_r,
   output logic [LEN_W-1:0] wire_len_r,
   output logic [LEN_W-1:0] pad_bytes_r,
   output logic fcs_append_r,
   output logic backoff_clear_r,
   output logic [15:0] pause_time_r
);
   // ==========================================================
   // Register state
   // ==========================================================
   mtxcs_txcfg_t cfg_r;
   mtxcs_txcfg_t cfg_nxt;
   mtxcs_txfc_t fc_nxt;
   logic [1:0] fc_bo_sel_r;
   mtxcs_txst_t st_r;
   mtxcs_txst_t st_nxt;
   logic [7:0] gap_r;
   logic [7:0] gap_nxt;
   logic [31:0] rd_mux;
   logic [CNT_W-1:0] defer_cnt;
   logic [CNT_W-1:0] pause_cnt;
   logic [LEN_W-1:0] wlen_nxt;
   logic [LEN_W-1:0] pad_nxt;

   // ==========================================================
   // APB decode
   // ==========================================================
   wire logic hit_cfg = (paddr == ADDR_W'(ADDR_TXCFG));
   wire logic hit_fc = (paddr == ADDR_W'(ADDR_TXFC));
   wire logic hit_defer = (paddr == ADDR_W'(ADDR_DEFER));
   wire logic hit_pause = (paddr == ADDR_W'(ADDR_PAUSE));
   wire logic hit_any = hit_cfg | hit_fc | hit_defer | hit_pause;
   wire logic setup = psel & ~penable;
   wire logic rd_setup = setup & ~pwrite;
   wire logic wr_acc = psel & penable & pready_r & pwrite;
   wire logic clr_defer = rd_setup & hit_defer;
   wire logic clr_pause = rd_setup & hit_pause;

   // Read mux, sampled at the setup edge
   always_comb begin
      rd_mux = 32'h00000000;
      if (hit_cfg) begin
         rd_mux = {24'h000000, cfg_r[7:0]};
      end else if (hit_fc) begin
         rd_mux = {14'h0000, pause_time_r, 2'b00} >> 2;
         rd_mux[17:16] = fc_bo_sel_r;
      end else if (hit_defer) begin
         rd_mux = 32'(defer_cnt);
      end else if (hit_pause) begin
         rd_mux = 32'(pause_cnt);
      end
   end

   // Register writes, reserved bits forced to zero
   always_comb begin
      cfg_nxt = cfg_r;
      fc_nxt = '{rsvd: 14'h0000, bo_sel: fc_bo_sel_r, pause_time: pause_time_r};
      if (wr_acc && hit_cfg) begin
         cfg_nxt = {24'h000000, pwdata[7:0]};
      end
      if (wr_acc && hit_fc) begin
         fc_nxt = {14'h0000, pwdata[17:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= TXCFG_RST;
         fc_bo_sel_r <= TXFC_RST.bo_sel;
         pause_time_r <= TXFC_RST.pause_time;
      end else begin
         cfg_r <= cfg_nxt;
         fc_bo_sel_r <= fc_nxt.bo_sel;
         pause_time_r <= fc_nxt.pause_time;
      end
   end

   // Zero-wait answer: ready during the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~hit_any;
         if (rd_setup) prdata_r <= rd_mux;
      end
   end

   // ==========================================================
   // Transmit sequencing and inter-frame gap
   // ==========================================================
   wire logic start_ok = tx_start & tx_permit_r;
   wire logic [7:0] gap_bits = {1'b0, cfg_r.ifg, 2'b00} + IFG_BASE_BITS;

   always_comb begin
      st_nxt = st_r;
      gap_nxt = gap_r;
      case (st_r)
         TX_IDLE: begin
            if (start_ok) st_nxt = TX_SEND;
         end
         TX_SEND: begin
            if (tx_end) begin
               st_nxt = TX_GAP;
               gap_nxt = gap_bits;
            end
         end
         TX_GAP: begin
            if (gap_r == 8'h00) st_nxt = TX_IDLE;
            else if (bit_tick) gap_nxt = gap_r - 8'h01;
         end
         default: st_nxt = TX_IDLE;
      endcase
   end

   wire logic permit_nxt = cfg_r.tx_en && (st_nxt == TX_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= TX_IDLE;
         gap_r <= 8'h00;
         tx_permit_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         gap_r <= gap_nxt;
         tx_permit_r <= permit_nxt;
      end
   end

   // ==========================================================
   // Padding and check sequence length
   // ==========================================================
   wire logic short_frame = (tx_len <= LEN_W'(PAD_MAX_LEN));

   always_comb begin
      wlen_nxt = tx_len;
      pad_nxt = '0;
      if (cfg_r.pad_en && short_frame) begin
         wlen_nxt = LEN_W'(PADDED_LEN);
         pad_nxt = LEN_W'(PADDED_LEN) - LEN_W'(FCS_BYTES) - tx_len;
      end else if (cfg_r.pad_en) begin
         wlen_nxt = tx_len + LEN_W'(FCS_BYTES);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_valid_r <= 1'b0;
         wire_len_r <= '0;
         pad_bytes_r <= '0;
         fcs_append_r <= 1'b0;
      end else begin
         len_valid_r <= start_ok;
         if (start_ok) begin
            wire_len_r <= wlen_nxt;
            pad_bytes_r <= pad_nxt;
            fcs_append_r <= cfg_r.pad_en;
         end
      end
   end

   // ==========================================================
   // Backoff attempt counter reset selection
   // ==========================================================
   wire logic bo_tx = (fc_bo_sel_r == BO_ON_TX) & evt.tx_ok;
   wire logic bo_rx = (fc_bo_sel_r == BO_ON_RX) & evt.rx_ok;
   wire logic bo_any = fc_bo_sel_r[1] & (evt.tx_ok | evt.rx_ok);
   wire logic bo_nxt = half_duplex & (bo_tx | bo_rx | bo_any);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) backoff_clear_r <= 1'b0;
      else backoff_clear_r <= bo_nxt;
   end

   // ==========================================================
   // Statistics counters
   // ==========================================================
   wire logic defer_inc = evt.defer_first & ~evt.collision & half_duplex;

   mtxcs_stat_counter #(
      .WIDTH(CNT_W),
      .PRELOAD(CNT_W'(PRELOAD_PKT))
   ) u_defer_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .inc(defer_inc),
      .rd_clr(clr_defer),
      .test_mode(cfg_r.cnt_test),
      .count_r(defer_cnt)
   );

   mtxcs_stat_counter #(
      .WIDTH(CNT_W),
      .PRELOAD(CNT_W'(PRELOAD_PKT))
   ) u_pause_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .inc(evt.pause_sent),
      .rd_clr(clr_pause),
      .test_mode(cfg_r.cnt_test),
      .count_r(pause_cnt)
   );

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_frame_done;
      st_r == TX_SEND && tx_end;
   endsequence

   sequence s_wr_fc;
      wr_acc && hit_fc;
   endsequence

   chk_gap_load: assert property (s_frame_done |=> gap_r == $past(gap_bits))
      else $error("gap not loaded with setting times four plus twelve");
   chk_gap_value: assert property (s_frame_done and cfg_r.ifg == IFG_RST |=> gap_r == 8'h60)
      else $error("default gap is not 96 bit times");
   chk_pad_short: assert property (start_ok && cfg_r.pad_en && tx_len <= LEN_W'(PAD_MAX_LEN)
      |=> len_valid_r && wire_len_r == LEN_W'(PADDED_LEN))
      else $error("short frame not padded to 64 bytes");
   chk_pad_mid: assert property (start_ok && cfg_r.pad_en && tx_len > LEN_W'(PAD_MAX_LEN)
      |=> wire_len_r == $past(tx_len) + LEN_W'(FCS_BYTES) && pad_bytes_r == '0)
      else $error("frame above 60 bytes padded or missing check bytes");
   chk_tx_disabled: assert property (!cfg_r.tx_en |=> !tx_permit_r ##1 !len_valid_r)
      else $error("transmitter active while disabled");
   chk_backoff_tx: assert property (half_duplex && evt.tx_ok && fc_bo_sel_r != BO_ON_RX
      |=> backoff_clear_r)
      else $error("backoff not reset after transmission");
   chk_backoff_full: assert property (!half_duplex |=> !backoff_clear_r)
      else $error("backoff reset in full duplex");
   chk_defer_full: assert property (!half_duplex && !clr_defer |=> $stable(defer_cnt))
      else $error("deferred counter moved in full duplex");
   chk_defer_coll: assert property (evt.collision && !clr_defer |=> $stable(defer_cnt))
      else $error("deferred counter moved on collision");
   chk_defer_inc: assert property (defer_inc && !clr_defer && !(&defer_cnt)
      |=> defer_cnt == $past(defer_cnt) + CNT_W'(1))
      else $error("deferred frame not counted");
   chk_pause_inc: assert property (evt.pause_sent && !clr_pause && !(&pause_cnt)
      |=> pause_cnt == $past(pause_cnt) + CNT_W'(1))
      else $error("pause frame not counted");
   chk_pause_time: assert property (s_wr_fc |=> pause_time_r == $past(pwdata[15:0]))
      else $error("pause time not taken from write");
   chk_read_value: assert property (rd_setup && hit_defer
      |=> pready_r && prdata_r == $past(defer_cnt) ##1 !pready_r)
      else $error("read did not return counter value");

   // ==========================================================
   // Bus, counter and transmit path checks
   // ==========================================================
   sequence s_clr_pause;
      clr_pause && !evt.pause_sent;
   endsequence

   sequence s_clr_defer;
      clr_defer && !defer_inc;
   endsequence

   sequence s_gap_run;
      st_r == TX_GAP && gap_r != 8'h00;
   endsequence

   chk_ready_once: assert property (setup |=> pready_r ##1 !pready_r)
      else $error("access not answered exactly once");
   chk_read_pause: assert property (rd_setup && hit_pause
      |=> prdata_r == $past(pause_cnt))
      else $error("pause read value wrong");
   chk_pause_clr: assert property (s_clr_pause and !cfg_r.cnt_test
      |=> pause_cnt == '0)
      else $error("pause counter not cleared");
   chk_pause_pre: assert property (s_clr_pause and cfg_r.cnt_test
      |=> pause_cnt == CNT_W'(PRELOAD_PKT))
      else $error("pause counter not preloaded");
   chk_pause_keep: assert property (clr_pause && evt.pause_sent && !cfg_r.cnt_test
      |=> pause_cnt == CNT_W'(1))
      else $error("pause event lost at read");
   chk_defer_clr: assert property (s_clr_defer and !cfg_r.cnt_test
      |=> defer_cnt == '0)
      else $error("deferred counter not cleared");
   chk_defer_pre: assert property (s_clr_defer and cfg_r.cnt_test
      |=> defer_cnt == CNT_W'(PRELOAD_PKT))
      else $error("deferred counter not preloaded");
   chk_pause_sat: assert property (&pause_cnt && !clr_pause |=> &pause_cnt)
      else $error("pause counter wrapped");
   chk_defer_sat: assert property (&defer_cnt && !clr_defer |=> &defer_cnt)
      else $error("deferred counter wrapped");

   chk_backoff_rx: assert property (half_duplex && evt.rx_ok
      && fc_bo_sel_r != BO_ON_TX |=> backoff_clear_r)
      else $error("backoff not reset after reception");
   chk_backoff_idle: assert property (!evt.tx_ok && !evt.rx_ok |=> !backoff_clear_r)
      else $error("backoff reset without success");
   chk_backoff_sel: assert property (fc_bo_sel_r == BO_ON_RX && !evt.rx_ok
      |=> !backoff_clear_r)
      else $error("backoff reset on unselected event");

   chk_nopad_len: assert property (start_ok && !cfg_r.pad_en
      |=> wire_len_r == $past(tx_len) && !fcs_append_r)
      else $error("frame changed with padding off");
   chk_pad_fill: assert property (start_ok && cfg_r.pad_en && short_frame
      |=> fcs_append_r && pad_bytes_r == LEN_W'(PAD_MAX_LEN) - $past(tx_len))
      else $error("pad byte count wrong");
   chk_start_busy: assert property (start_ok
      |=> !tx_permit_r && len_valid_r ##1 !len_valid_r)
      else $error("start not taken exactly once");
   chk_gap_wait: assert property (s_gap_run |=> !tx_permit_r)
      else $error("permit given inside the gap");
   chk_gap_step: assert property (s_gap_run and bit_tick
      |=> gap_r == $past(gap_r) - 8'h01)
      else $error("gap not counted per bit time");
   chk_gap_done: assert property (st_r == TX_GAP && gap_r == 8'h00 && cfg_r.tx_en
      |=> tx_permit_r)
      else $error("permit missing after the gap");
   chk_pause_hold: assert property (!(wr_acc && hit_fc) |=> $stable(pause_time_r))
      else $error("pause time changed without write");
endmodule : mtxcs_top

/* shared/mtxcs_pkg.sv */
// Package for the transmit configuration and statistics block
// Operation
// - Test bit set: reading a packet counter reloads it with 7FFF_FFFCh.
// - Test bit set: the three byte counters reload with 7FFF_F80h instead; no byte counters are built here.
// - Gap in bit times is setting times four plus twelve; setting resets to 10101b.
// - Pad enable pads short frames with zeros and appends a check sequence; resets one.
// - With padding, frames of sixty bytes or fewer go out as sixty-four bytes.
// - With padding, 61 to 63 byte frames only gain four check bytes.
// - Transmitter runs only while transmit enable is one; resets to one.
// - Two-bit field picks the backoff counter reset event, half duplex only.
// - Backoff select 00 after transmit, 01 after receive, 1X after either.
// - Transmitted pause frames carry the sixteen-bit pause time; resets to all ones.
// - Deferred counter counts frames deferred on first attempt by a busy medium.
// - Collisions never increment the deferred counter.
// - Deferred counter counts only in half duplex.
// - Counters return their value on read and then clear to zero.
// - Counters saturate at all ones instead of wrapping.
// - Pause counter counts each transmitted pause frame.
package mtxcs_pkg;
   // ==========================================================
   // Register map (index times four is the byte address)
   // ==========================================================
   localparam logic [15:0] IDX_TXCFG = 16'h0440;
   localparam logic [15:0] IDX_TXFC = 16'h0441;
   localparam logic [15:0] IDX_DEFER = 16'h0451;
   localparam logic [15:0] IDX_PAUSE = 16'h0452;
   localparam logic [15:0] ADDR_TXCFG = {IDX_TXCFG[13:0], 2'b00};
   localparam logic [15:0] ADDR_TXFC = {IDX_TXFC[13:0], 2'b00};
   localparam logic [15:0] ADDR_DEFER = {IDX_DEFER[13:0], 2'b00};
   localparam logic [15:0] ADDR_PAUSE = {IDX_PAUSE[13:0], 2'b00};

   // ==========================================================
   // Field layouts
   // ==========================================================
   typedef struct packed {
      logic [23:0] rsvd;
      logic cnt_test;
      logic [4:0] ifg;
      logic pad_en;
      logic tx_en;
   } mtxcs_txcfg_t;

   typedef struct packed {
      logic [13:0] rsvd;
      logic [1:0] bo_sel;
      logic [15:0] pause_time;
   } mtxcs_txfc_t;

   // Events reported by the MAC core, one-cycle pulses
   typedef struct packed {
      logic tx_ok;
      logic rx_ok;
      logic defer_first;
      logic collision;
      logic pause_sent;
   } mtxcs_evt_t;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [4:0] IFG_RST = 5'h15;
   localparam mtxcs_txcfg_t TXCFG_RST = '{rsvd: 24'h000000, cnt_test: 1'b0,
      ifg: IFG_RST, pad_en: 1'b1, tx_en: 1'b1};
   localparam mtxcs_txfc_t TXFC_RST = '{rsvd: 14'h0000, bo_sel: 2'h0,
      pause_time: 16'hFFFF};

   // ==========================================================
   // Backoff reset encodings
   // ==========================================================
   localparam logic [1:0] BO_ON_TX = 2'h0;
   localparam logic [1:0] BO_ON_RX = 2'h1;

   // ==========================================================
   // Gap and length constants
   // ==========================================================
   localparam logic [7:0] IFG_BASE_BITS = 8'h0C;
   localparam logic [4:0] IFG_MIN_SUPPORTED = 5'h0F;
   localparam logic [11:0] PAD_MAX_LEN = 12'h03C;
   localparam logic [11:0] PADDED_LEN = 12'h040;
   localparam logic [11:0] FCS_BYTES = 12'h004;

   // ==========================================================
   // Counter preload values for test mode
   // ==========================================================
   localparam logic [31:0] PRELOAD_PKT = 32'h7FFFFFFC;
   localparam logic [31:0] PRELOAD_BYTE = 32'h07FFFF80;

   // Transmit sequencing, one bit changes per step except TX_GAP back to TX_IDLE
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_GAP = 2'b11
   } mtxcs_txst_t;
endpackage : mtxcs_pkg

/* verilog/mtxcs_stat_counter.sv */
// Clear-on-read saturating statistics counter
`timescale 1ns/1ns
module mtxcs_stat_counter #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] PRELOAD = WIDTH'(32'h7FFFFFFC)
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic inc,
   input wire logic rd_clr,
   input wire logic test_mode,
   // Value
   output logic [WIDTH-1:0] count_r
);
   logic [WIDTH-1:0] count_nxt;
   wire logic at_max = &count_r;
   wire logic [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};
   wire logic [WIDTH-1:0] rd_base = test_mode ? PRELOAD : '0;

   always_comb begin
      count_nxt = count_r;
      if (rd_clr) begin
         count_nxt = inc ? rd_base + one : rd_base;
      end else if (inc && !at_max) begin
         count_nxt = count_r + one;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) count_r <= '0;
      else count_r <= count_nxt;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_read_clears: assert property (rd_clr && !inc && !test_mode |=> count_r == '0)
      else $error("counter not cleared by read");
   chk_test_preload: assert property (rd_clr && !inc && test_mode |=> count_r == PRELOAD)
      else $error("counter not preloaded in test mode");
   chk_saturate_hold: assert property (at_max && !rd_clr |=> at_max)
      else $error("counter wrapped past all ones");
   chk_read_coincide: assert property (rd_clr && inc && !test_mode |=> count_r == one)
      else $error("increment lost during clearing read");
endmodule : mtxcs_stat_counter

/* testbench/mtxcs_mac_model.sv */
// Behavioural MAC core that starts and ends frames on the transmit path
`timescale 1ns/1ns
module mtxcs_mac_model #(
   parameter int LEN_W = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // From the block
   input wire logic tx_permit_r,
   // Toward the block
   output logic bit_tick,
   output logic tx_start,
   output logic [LEN_W-1:0] tx_len,
   output logic tx_end
);
   initial begin
      bit_tick = 1'b0;
      tx_start = 1'b0;
      tx_len = '0;
      tx_end = 1'b0;
   end
   // One bit time every other clock
   always @(posedge pclk) begin
      bit_tick <= presetn & ~bit_tick;
   end
   // Start when permitted, keep the frame dur cycles, then end it
   task automatic send(input logic [LEN_W-1:0] len, input int dur);
      @(negedge pclk);
      while (tx_permit_r !== 1'b1) @(negedge pclk);
      @(posedge pclk);
      tx_start <= 1'b1;
      tx_len <= len;
      @(posedge pclk);
      tx_start <= 1'b0;
      // Length no longer qualified
      tx_len <= ~len;
      repeat (dur) @(posedge pclk);
      tx_end <= 1'b1;
      @(posedge pclk);
      tx_end <= 1'b0;
   endtask : send
endmodule : mtxcs_mac_model

/* testbench/testbench.sv */
// Self-checking bench for the transmit configuration and statistics block
`timescale 1ns/1ns
module testbench;
   import mtxcs_pkg::*;
   // ==========================================
   // Signals
   // ==========================================
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready_r, pslverr_r, half_duplex;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata_r, rv;
   logic re, bit_tick, tx_start, tx_end, tx_permit_r, len_valid_r;
   logic fcs_append_r, backoff_clear_r;
   logic [11:0] tx_len, wire_len_r, pad_bytes_r;
   logic [15:0] pause_time_r;
   mtxcs_evt_t evt;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   int n_lv = 0;
   always #4 pclk = ~pclk;
   always @(posedge pclk) if (len_valid_r === 1'b1) n_lv <= n_lv + 1;
   mtxcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
      .pready_r(pready_r), .pslverr_r(pslverr_r), .half_duplex(half_duplex),
      .bit_tick(bit_tick), .tx_start(tx_start), .tx_len(tx_len), .tx_end(tx_end),
      .evt(evt), .tx_permit_r(tx_permit_r), .len_valid_r(len_valid_r),
      .wire_len_r(wire_len_r), .pad_bytes_r(pad_bytes_r), .fcs_append_r(fcs_append_r),
      .backoff_clear_r(backoff_clear_r), .pause_time_r(pause_time_r));
   mtxcs_mac_model mac (.pclk(pclk), .presetn(presetn), .tx_permit_r(tx_permit_r),
      .bit_tick(bit_tick), .tx_start(tx_start), .tx_len(tx_len), .tx_end(tx_end));
   // ==========================================
   // Shared tasks
   // ==========================================
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("MISMATCH at %0t: run timed out", $time);
         summarize();
      end
   end
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] v, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready_r !== 1'b1) @(posedge pclk);
      v = prdata_r;
      e = pslverr_r;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Pulse one event and count backoff clears seen after it
   task automatic pulse(input logic [4:0] e, output int seen);
      evt <= mtxcs_evt_t'(e);
      @(posedge pclk);
      evt <= '0;
      seen = 0;
      repeat (3) begin
         @(posedge pclk);
         if (backoff_clear_r === 1'b1) seen++;
      end
   endtask : pulse
   // ==========================================
   // Scenarios
   // ==========================================
   task automatic t_regs;
      apb(0, ADDR_TXCFG, '0, rv, re);
      check(rv, 32'h00000057, "txcfg reset");
      apb(0, ADDR_TXFC, '0, rv, re);
      check(rv, 32'h0000FFFF, "txfc reset");
      check(pause_time_r, 32'h0000FFFF, "pause out reset");
      apb(0, 16'h1108, '0, rv, re);
      check({rv[30:0], re}, 32'h00000001, "unmapped read");
      apb(1, ADDR_TXFC, 32'hFFFF1234, rv, re);
      apb(0, ADDR_TXFC, '0, rv, re);
      check(rv, 32'h00031234, "txfc readback");
      check(pause_time_r, 32'h00001234, "pause out");
      apb(1, ADDR_DEFER, 32'h00000005, rv, re);
      apb(0, ADDR_DEFER, '0, rv, re);
      check(rv, 32'h00000000, "counter write ignored");
      $display("test regs done");
   endtask : t_regs
   task automatic t_pad;
      logic [11:0] lens[6] = '{12'h028, 12'h03C, 12'h03D, 12'h03E, 12'h03F, 12'h064};
      foreach (lens[i]) begin
         mac.send(lens[i], 2);
         check(wire_len_r, lens[i] <= 12'h03C ? 12'h040 : lens[i] + 12'h004, "wire");
         check(pad_bytes_r, lens[i] <= 12'h03C ? 12'h03C - lens[i] : 12'h000, "pad");
         check(fcs_append_r, 1'b1, "fcs on");
      end
      check(n_lv, 6, "starts taken");
      apb(1, ADDR_TXCFG, 32'h00000055, rv, re);
      mac.send(12'h028, 2);
      check({wire_len_r, pad_bytes_r, 7'h00, fcs_append_r}, {12'h028, 20'h0}, "no pad");
      apb(1, ADDR_TXCFG, 32'h00000057, rv, re);
      $display("test pad done");
   endtask : t_pad
   task automatic t_gap;
      logic [4:0] ifg;
      int g, n;
      for (int i = 0; i < 2; i++) begin
         // Lowest supported setting first
         ifg = i ? 5'h15 : 5'h0F;
         g = 4 * ifg + 12;
         apb(1, ADDR_TXCFG, {24'h0, 1'b0, ifg, 2'b11}, rv, re);
         mac.send(12'h040, 3);
         n = 0;
         while (tx_permit_r !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
         end
         check(n >= 2 * g - 2 && n <= 2 * g + 6, 1, "gap length");
      end
      apb(1, ADDR_TXCFG, 32'h00000056, rv, re);
      repeat (10) @(posedge pclk);
      check(tx_permit_r, 1'b0, "disabled");
      apb(1, ADDR_TXCFG, 32'h00000057, rv, re);
      repeat (2) @(posedge pclk);
      check(tx_permit_r, 1'b1, "enabled");
      $display("test gap done");
   endtask : t_gap
   task automatic t_count;
      int s;
      half_duplex <= 1'b1;
      pulse(5'b00100, s);
      pulse(5'b00110, s);
      half_duplex <= 1'b0;
      pulse(5'b00100, s);
      apb(0, ADDR_DEFER, '0, rv, re);
      check(rv, 32'h00000001, "deferred");
      apb(0, ADDR_DEFER, '0, rv, re);
      check(rv, 32'h00000000, "deferred cleared");
      repeat (3) pulse(5'b00001, s);
      apb(0, ADDR_PAUSE, '0, rv, re);
      check(rv, 32'h00000003, "pause count");
      apb(0, ADDR_PAUSE, '0, rv, re);
      check(rv, 32'h00000000, "pause cleared");
      repeat (2) pulse(5'b00001, s);
      fork
         apb(0, ADDR_PAUSE, '0, rv, re);
         pulse(5'b00001, s);
      join
      check(rv, 32'h00000002, "read with event");
      apb(0, ADDR_PAUSE, '0, rv, re);
      check(rv, 32'h00000001, "event kept");
      $display("test counters done");
   endtask : t_count
   task automatic t_preload;
      int s;
      apb(1, ADDR_TXCFG, 32'h000000D7, rv, re);
      apb(0, ADDR_PAUSE, '0, rv, re);
      apb(0, ADDR_PAUSE, '0, rv, re);
      check(rv, PRELOAD_PKT, "preload");
      repeat (2) pulse(5'b00001, s);
      apb(0, ADDR_PAUSE, '0, rv, re);
      check(rv, 32'h7FFFFFFE, "preload counts");
      apb(0, ADDR_DEFER, '0, rv, re);
      apb(0, ADDR_DEFER, '0, rv, re);
      check(rv, PRELOAD_PKT, "defer preload");
      apb(1, ADDR_TXCFG, 32'h00000057, rv, re);
      apb(0, ADDR_PAUSE, '0, rv, re);
      apb(0, ADDR_PAUSE, '0, rv, re);
      check(rv, 32'h00000000, "normal clear");
      $display("test preload done");
   endtask : t_preload
   task automatic t_backoff;
      int s;
      half_duplex <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         apb(1, ADDR_TXFC, {14'h0, 2'(b), 16'hFFFF}, rv, re);
         pulse(5'b10000, s);
         check(s, b != 1, "clear on tx");
         pulse(5'b01000, s);
         check(s, b != 0, "clear on rx");
      end
      half_duplex <= 1'b0;
      pulse(5'b10000, s);
      check(s, 0, "full duplex");
      $display("test backoff done");
   endtask : t_backoff
   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      half_duplex = 1'b0;
      evt = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_pad();
      t_gap();
      t_count();
      t_preload();
      t_backoff();
      summarize();
   end
endmodule : testbench
